//--- cwad_datapath.sv
/*
  Arithmetic datapath of the core: wide add and subtract, multiply, divide,
  multiply-accumulate and absolute-difference loops, increments, decimal adjust.
  Assumes the sequencer supplies operands and writes results back to the
  register file; loop operands come from memory over the read port.
*/
`include "cwad_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module cwad_datapath (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire cwad_pkg::cwad_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output var cwad_pkg::cwad_rsp_t rsp,
  output logic mem_rd,
  output logic [23:0] mem_addr_a,
  output logic [23:0] mem_addr_b,
  input wire logic mem_ack,
  input wire logic [15:0] mem_data_a,
  input wire logic [15:0] mem_data_b
);
  import cwad_pkg::*;

  // width-generic add or subtract: operands are left-aligned so the carry
  // and overflow always come out of bit 31 whatever the width
  function automatic cwad_alu_t arith(input logic [31:0] a, input logic [31:0] b,
                                      input logic sub, input logic [5:0] w);
    logic [5:0] sh;
    logic [31:0] al;
    logic [31:0] bl;
    logic [32:0] sum;
    cwad_alu_t r;
    sh = `CWAD_W32 - w;
    al = a << sh;
    bl = b << sh;
    sum = sub ? ({1'b0, al} - {1'b0, bl}) : ({1'b0, al} + {1'b0, bl});
    r.res = sum[31:0] >> sh;
    r.f.cy = sum[32];
    r.f.s = sum[31];
    r.f.z = (sum[31:0] == 32'h0);
    r.f.pv = sub ? ((al[31] != bl[31]) && (sum[31] != al[31]))
                 : ((al[31] == bl[31]) && (sum[31] != al[31]));
    r.f.ac = a[4] ^ b[4] ^ r.res[4];
    return r;
  endfunction

  cwad_state_t q;
  cwad_state_t d;
  cwad_alu_t alu;
  logic take;
  logic stop;
  logic [7:0] cnt_n;
  logic [7:0] fix;
  logic [7:0] bcd;
  logic [15:0] mag;
  logic [15:0] pb;
  logic [31:0] pw;
  logic signed [31:0] ps;
  logic signed [31:0] mp;
  logic [15:0] dq16;
  logic [15:0] dr16;
  logic [31:0] dq32;
  logic [31:0] dr32;

  assign take = req_valid && q.idle;

  always_comb begin
    d = q;
    alu = '0;
    stop = 1'b0;
    cnt_n = q.rsp.cnt - `CWAD_CNT_STEP;
    fix = 8'h00;
    bcd = 8'h00;
    mag = 16'h0;
    pb = req.opa[7:0] * req.opb[7:0];
    pw = req.opa[15:0] * req.opb[15:0];
    ps = $signed(req.opa[15:0]) * $signed(req.opb[15:0]);
    // loop product sized by its target so no tool keeps only sixteen bits of it
    mp = $signed(mem_data_a) * $signed(mem_data_b);
    dq16 = req.opa[15:0] / {8'h00, req.opb[7:0]};
    dr16 = req.opa[15:0] % {8'h00, req.opb[7:0]};
    dq32 = req.opa / {16'h0, req.opb[15:0]};
    dr32 = req.opa % {16'h0, req.opb[15:0]};
    d.rsp_valid = 1'b0;
    if (take) begin
      d.op = req.op;
      d.rsp_valid = 1'b1;
      d.rsp.aux = 16'h0;
      d.rsp.flag_we = '0;
      d.rsp.ptr_a = req.ptr_a;
      d.rsp.ptr_b = req.ptr_b;
      d.rsp.cnt = req.cnt;
      unique case (req.op)
        OP_WIDE_ADD, OP_WIDE_SUBTRACT: begin
          alu = arith(req.opa, req.opb, req.op == OP_WIDE_SUBTRACT, `CWAD_W24);
          d.rsp.res = alu.res;
          d.rsp.flags = alu.f;
          d.rsp.flag_we = '1;
        end
        OP_WORD_ADD, OP_WORD_SUBTRACT, OP_WORD_COMPARE: begin
          alu = arith(req.opa, req.opb, req.op != OP_WORD_ADD, `CWAD_W16);
          // compare leaves the first operand standing as the result
          d.rsp.res = (req.op == OP_WORD_COMPARE) ? {16'h0, req.opa[15:0]} : alu.res;
          d.rsp.flags = alu.f;
          d.rsp.flag_we = '1;
        end
        OP_BYTE_PLUS_ONE, OP_BYTE_MINUS_ONE: begin
          alu = arith(req.opa, 32'h1, req.op == OP_BYTE_MINUS_ONE, `CWAD_W8);
          d.rsp.res = alu.res;
          d.rsp.flags = alu.f;
          d.rsp.flag_we = '{s: 1'b1, z: 1'b1, ac: 1'b1, pv: 1'b1, cy: 1'b0};
        end
        OP_WORD_PLUS_ONE, OP_WORD_MINUS_ONE: begin
          alu = arith(req.opa, 32'h1, req.op == OP_WORD_MINUS_ONE, `CWAD_W16);
          d.rsp.res = alu.res;
        end
        OP_WIDE_PLUS_ONE, OP_WIDE_MINUS_ONE: begin
          alu = arith(req.opa, 32'h1, req.op == OP_WIDE_MINUS_ONE, `CWAD_W24);
          d.rsp.res = alu.res;
        end
        OP_BYTE_UNSIGNED_MULTIPLY: d.rsp.res = {16'h0, pb};
        OP_WORD_UNSIGNED_MULTIPLY: begin
          d.rsp.res = {16'h0, pw[31:16]};
          d.rsp.aux = pw[15:0];
        end
        OP_WORD_SIGNED_MULTIPLY: begin
          d.rsp.res = {16'h0, ps[31:16]};
          d.rsp.aux = ps[15:0];
        end
        OP_WORD_BY_BYTE_DIVIDE: begin
          if (req.opb[7:0] == 8'h00) begin
            d.rsp.res = {16'h0, `CWAD_ONES16};
            d.rsp.aux = {8'h00, req.opa[7:0]};
          end else begin
            d.rsp.res = {16'h0, dq16};
            d.rsp.aux = {8'h00, dr16[7:0]};
          end
        end
        OP_LONG_BY_WORD_DIVIDE: begin
          if (req.opb[15:0] == 16'h0) begin
            d.rsp.res = `CWAD_ONES32;
            d.rsp.aux = req.opa[15:0];
          end else begin
            d.rsp.res = dq32;
            d.rsp.aux = dr32[15:0];
          end
        end
        OP_BCD_FIX_AFTER_ADD, OP_BCD_FIX_AFTER_SUBTRACT: begin
          if (req.ac_in || (req.opa[3:0] > `CWAD_BCD_DIGIT_MAX)) begin
            fix = fix | `CWAD_BCD_LO_FIX;
          end
          if (req.cy_in || (req.opa[7:0] > `CWAD_BCD_BYTE_MAX)) begin
            fix = fix | `CWAD_BCD_HI_FIX;
          end
          bcd = (req.op == OP_BCD_FIX_AFTER_ADD) ? req.opa[7:0] + fix : req.opa[7:0] - fix;
          d.rsp.res = {24'h0, bcd};
          d.rsp.flags.s = bcd[7];
          d.rsp.flags.z = (bcd == 8'h00);
          d.rsp.flags.ac = req.opa[4] ^ fix[4] ^ bcd[4];
          d.rsp.flags.pv = ~^bcd;
          d.rsp.flags.cy = req.cy_in || (req.opa[7:0] > `CWAD_BCD_BYTE_MAX);
          d.rsp.flag_we = '1;
        end
        OP_SIGN_EXTEND_BYTE: begin
          d.rsp.res = {16'h0, req.opa[7] ? `CWAD_EXT_ONES : `CWAD_EXT_ZERO, req.opa[7:0]};
        end
        OP_MULTIPLY_ACCUMULATE_LOOP, OP_SATURATING_MULTIPLY_ACCUMULATE,
        OP_ABSOLUTE_DIFFERENCE_SUM: begin
          // loops answer only when they end; memory reads start next cycle
          d.rsp_valid = 1'b0;
          d.rsp.res = req.opa;
          d.rsp.flag_we = '1;
          d.st = S_LOOP;
          d.idle = 1'b0;
          d.mem_rd = 1'b1;
        end
        // unused codes answer zero and leave every flag alone
        default: d.rsp.res = 32'h0;
      endcase
    end else if (q.st == S_LOOP && mem_ack) begin
      if (q.op == OP_ABSOLUTE_DIFFERENCE_SUM) begin
        mag = (mem_data_a >= mem_data_b) ? mem_data_a - mem_data_b : mem_data_b - mem_data_a;
        alu = arith({16'h0, q.rsp.res[15:0]}, {16'h0, mag}, 1'b0, `CWAD_W16);
        d.rsp.res = {q.rsp.res[31:16], alu.res[15:0]};
        stop = (cnt_n == 8'h00) || alu.f.cy;
      end else begin
        alu = arith(q.rsp.res, mp, 1'b0, `CWAD_W32);
        d.rsp.res = alu.res;
        stop = (cnt_n == 8'h00) || alu.f.pv;
        if (q.op == OP_SATURATING_MULTIPLY_ACCUMULATE && alu.f.pv) begin
          // overflow can only come from two equal signs, so the old sign tells the limit
          d.rsp.res = q.rsp.res[31] ? `CWAD_SAT_NEG : `CWAD_SAT_POS;
        end
      end
      d.rsp.flags = alu.f;
      d.rsp.ptr_a = q.rsp.ptr_a + `CWAD_PTR_STEP;
      d.rsp.ptr_b = q.rsp.ptr_b + `CWAD_PTR_STEP;
      d.rsp.cnt = cnt_n;
      if (stop) begin
        d.st = S_IDLE;
        d.idle = 1'b1;
        d.mem_rd = 1'b0;
        d.rsp_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      q <= '0;
      q.idle <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign req_ready = q.idle;
  assign rsp_valid = q.rsp_valid;
  assign rsp = q.rsp;
  assign mem_rd = q.mem_rd;
  assign mem_addr_a = q.rsp.ptr_a;
  assign mem_addr_b = q.rsp.ptr_b;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_take_op(cwad_op_t o);
    take && req.op == o;
  endsequence

  sequence s_step;
    q.st == S_LOOP && mem_ack;
  endsequence

  AST_WIDE_ADD: assert property (s_take_op(OP_WIDE_ADD) |=> rsp_valid
    && rsp.res[23:0] == 24'($past(req.opa) + $past(req.opb)) && rsp.flag_we == '1)
    else $error("wide add result or flags wrong");
  AST_WIDE_SUB_BORROW: assert property (s_take_op(OP_WIDE_SUBTRACT) |=>
    rsp.flags.cy == ($past(req.opa[23:0]) < $past(req.opb[23:0])))
    else $error("wide subtract borrow wrong");
  AST_WORD_MUL: assert property (s_take_op(OP_WORD_UNSIGNED_MULTIPLY) |=>
    {rsp.res[15:0], rsp.aux} == $past(req.opa[15:0]) * $past(req.opb[15:0])
    && rsp.flag_we == '0)
    else $error("word multiply halves or flags wrong");
  AST_BYTE_DIV_ZERO: assert property (take && req.op == OP_WORD_BY_BYTE_DIVIDE
    && req.opb[7:0] == 8'h00 |=> rsp.res[15:0] == 16'hffff
    && rsp.aux[7:0] == $past(req.opa[7:0]))
    else $error("byte divide by zero result wrong");
  AST_LONG_DIV_ZERO: assert property (take && req.op == OP_LONG_BY_WORD_DIVIDE
    && req.opb[15:0] == 16'h0 |=> rsp.res == 32'hffffffff
    && rsp.aux == $past(req.opa[15:0]))
    else $error("long divide by zero result wrong");
  AST_LOOP_STEP: assert property (s_step |=> rsp.ptr_a == $past(rsp.ptr_a) + 24'h2
    && rsp.cnt == $past(rsp.cnt) - 8'h1)
    else $error("loop step pointers or count wrong");
  AST_LOOP_END: assert property (s_step ##0 (rsp.cnt == 8'h01) |=> rsp_valid && req_ready
    && !mem_rd)
    else $error("loop did not end at zero count");
  AST_SAT_CLAMP: assert property (s_step ##0 q.op == OP_SATURATING_MULTIPLY_ACCUMULATE
    ##1 rsp.flags.pv |-> rsp_valid
    && (rsp.res == 32'h7fffffff || rsp.res == 32'h80000000))
    else $error("saturating loop did not clamp and end");
  AST_LOOP_NO_EARLY: assert property (s_take_op(OP_ABSOLUTE_DIFFERENCE_SUM) |=>
    !rsp_valid && mem_rd && mem_addr_a == $past(req.ptr_a))
    else $error("difference loop start wrong");
  AST_BYTE_INC_CARRY: assert property (s_take_op(OP_BYTE_PLUS_ONE) |=>
    !rsp.flag_we.cy && rsp.flag_we.z && rsp.res[7:0] == $past(req.opa[7:0]) + 8'h1)
    else $error("byte increment flags wrong");
  AST_SIGN_EXT: assert property (s_take_op(OP_SIGN_EXTEND_BYTE) |=>
    rsp.res[15:8] == {8{$past(req.opa[7])}} && rsp.flag_we == '0)
    else $error("sign extension wrong");

endmodule

`default_nettype wire

//--- cwad_defines.svh
/*
  Constants for the wide arithmetic datapath: operand widths, step sizes,
  fixed results and decimal-adjust thresholds.
  Assumes nothing; included by bare name wherever a figure is needed.
*/
`ifndef CWAD_DEFINES_SVH
`define CWAD_DEFINES_SVH

`define CWAD_W8 6'd8
`define CWAD_W16 6'd16
`define CWAD_W24 6'd24
`define CWAD_W32 6'd32
`define CWAD_PTR_STEP 24'h000002
`define CWAD_CNT_STEP 8'h01
`define CWAD_ONES16 16'hffff
`define CWAD_ONES32 32'hffffffff
`define CWAD_SAT_POS 32'h7fffffff
`define CWAD_SAT_NEG 32'h80000000
`define CWAD_EXT_ZERO 8'h00
`define CWAD_EXT_ONES 8'hff
`define CWAD_BCD_DIGIT_MAX 4'h9
`define CWAD_BCD_BYTE_MAX 8'h99
`define CWAD_BCD_LO_FIX 8'h06
`define CWAD_BCD_HI_FIX 8'h60

`endif

//--- cwad_pkg.sv
/*
  Types of the wide arithmetic datapath: operation codes, flag set,
  request and answer carriers, and the module state.
  Assumes the sequencer and the datapath share these definitions.
*/
package cwad_pkg;

  typedef enum logic [4:0] {
    OP_WIDE_ADD, OP_WIDE_SUBTRACT, OP_WORD_ADD, OP_WORD_SUBTRACT, OP_WORD_COMPARE,
    OP_BYTE_PLUS_ONE, OP_BYTE_MINUS_ONE, OP_WORD_PLUS_ONE, OP_WORD_MINUS_ONE,
    OP_WIDE_PLUS_ONE, OP_WIDE_MINUS_ONE, OP_BYTE_UNSIGNED_MULTIPLY,
    OP_WORD_UNSIGNED_MULTIPLY, OP_WORD_SIGNED_MULTIPLY, OP_WORD_BY_BYTE_DIVIDE,
    OP_LONG_BY_WORD_DIVIDE, OP_MULTIPLY_ACCUMULATE_LOOP, OP_SATURATING_MULTIPLY_ACCUMULATE,
    OP_ABSOLUTE_DIFFERENCE_SUM, OP_BCD_FIX_AFTER_ADD, OP_BCD_FIX_AFTER_SUBTRACT,
    OP_SIGN_EXTEND_BYTE
  } cwad_op_t;

  typedef struct packed {
    logic s;
    logic z;
    logic ac;
    logic pv;
    logic cy;
  } cwad_flags_t;

  typedef struct packed {
    cwad_op_t op;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [7:0] cnt;
    logic [23:0] ptr_a;
    logic [23:0] ptr_b;
    logic cy_in;
    logic ac_in;
  } cwad_req_t;

  typedef struct packed {
    logic [31:0] res;
    logic [15:0] aux;
    cwad_flags_t flags;
    cwad_flags_t flag_we;
    logic [23:0] ptr_a;
    logic [23:0] ptr_b;
    logic [7:0] cnt;
  } cwad_rsp_t;

  typedef struct packed {
    logic [31:0] res;
    cwad_flags_t f;
  } cwad_alu_t;

  typedef enum logic {S_IDLE, S_LOOP} cwad_fsm_t;

  typedef struct packed {
    cwad_fsm_t st;
    logic idle;
    logic rsp_valid;
    logic mem_rd;
    cwad_op_t op;
    cwad_rsp_t rsp;
  } cwad_state_t;

endpackage

//--- cwad_mem_model.sv
/*
  Loop memory seen by the datapath: answers word reads promptly or with random stalls.
  Assumes one core clock; each word is a fixed function of its address.
*/
`timescale 1ns/1ps
`default_nettype none

module cwad_mem_model (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic mem_rd,
  input wire logic [23:0] mem_addr_a,
  input wire logic [23:0] mem_addr_b,
  output logic mem_ack,
  output logic [15:0] mem_data_a,
  output logic [15:0] mem_data_b
);
  logic go_q;
  logic [15:0] junk_q;

  function automatic logic [15:0] word_at(input logic [23:0] a);
    return 16'(a * 24'h009e37) ^ 16'h1234;
  endfunction

  always_ff @(posedge core_clk) begin
    go_q <= reset_n && (!slow || ($urandom % 2 == 1));
    junk_q <= reset_n ? junk_q + 16'h3b1d : 16'h0f0f;
  end

  assign mem_ack = mem_rd && go_q;
  // no answer: the bus shows a moving pattern so stale data cannot pass for good data
  assign mem_data_a = mem_ack ? word_at(mem_addr_a) : junk_q;
  assign mem_data_b = mem_ack ? word_at(mem_addr_b) : ~junk_q;
endmodule

`default_nettype wire

//--- tb_cpu_wide_arith_datapath.sv
/*
  Self-checking bench for the wide arithmetic datapath: random and corner operands.
  Assumes cwad_pkg, the datapath and the loop memory model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_cpu_wide_arith_datapath;
  import cwad_pkg::*;
  logic core_clk, reset_n, req_valid, req_ready, rsp_valid, mem_rd, mem_ack, slow;
  cwad_req_t req;
  cwad_rsp_t rsp, r;
  logic [23:0] mem_addr_a, mem_addr_b;
  logic [15:0] mem_data_a, mem_data_b, d;
  logic [31:0] a, b, e;
  logic [24:0] s;
  int n_mismatch, samples_checked, k, j, x, y, p;

  cwad_datapath dut (.core_clk(core_clk), .reset_n(reset_n), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .mem_rd(mem_rd),
    .mem_addr_a(mem_addr_a), .mem_addr_b(mem_addr_b), .mem_ack(mem_ack),
    .mem_data_a(mem_data_a), .mem_data_b(mem_data_b));
  cwad_mem_model mem (.core_clk(core_clk), .reset_n(reset_n), .slow(slow), .mem_rd(mem_rd),
    .mem_addr_a(mem_addr_a), .mem_addr_b(mem_addr_b), .mem_ack(mem_ack),
    .mem_data_a(mem_data_a), .mem_data_b(mem_data_b));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  function automatic logic [15:0] word_at(input logic [23:0] ad);
    return 16'(ad * 24'h009e37) ^ 16'h1234;
  endfunction
  function automatic int prod(input int i);
    return $signed(word_at(24'(24'h100 + 2 * i))) * $signed(word_at(24'(24'h340 + 2 * i)));
  endfunction
  function automatic logic [7:0] bcd(input int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction

  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_flg(input cwad_flags_t got, input cwad_flags_t exp);
    chk_val(32'(got), 32'(exp));
  endtask

  // enter and leave on a rising edge; request held until the taking edge
  task automatic run(input cwad_op_t o, input logic [31:0] oa, input logic [31:0] ob,
                     input logic [7:0] c, input logic [1:0] ci);
    int i;
    req <= '{o, oa, ob, c, 24'h000100, 24'h000340, ci[1], ci[0]};
    req_valid <= 1'b1;
    @(posedge core_clk);
    req_valid <= 1'b0;
    #1;
    for (i = 0; i < 600 && rsp_valid !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (i == 600) begin
      n_mismatch++;
      test_done();
    end
    r = rsp;
    @(posedge core_clk);
  endtask

  initial begin
    reset_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    slow = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    k = $urandom(32'h8637);
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    for (k = 0; k < 24; k++) begin
      a = $urandom;
      b = $urandom;
      if (k < 2) begin
        a = k ? 32'h007fffff : 32'h00ffffff;
        b = 32'h1;
      end
      d = (k < 3) ? 16'h0 : b[15:0];
      s = {1'b0, a[23:0]} + {1'b0, b[23:0]};
      run(OP_WIDE_ADD, a, b, 8'h0, 2'b0);
      chk_val(32'(r.res[23:0]), 32'(s[23:0]));
      chk_val(32'(r.flags),
              32'({s[23], s[23:0] == 0, a[3:0] + b[3:0] > 15,
                   a[23] == b[23] && s[23] != a[23], s[24]}));
      s = {1'b0, a[23:0]} - {1'b0, b[23:0]};
      run(OP_WIDE_SUBTRACT, a, b, 8'h0, 2'b0);
      chk_val(32'({r.res[23:0], r.flags}),
              32'({s[23:0], s[23], s[23:0] == 0, a[3:0] < b[3:0],
                   a[23] != b[23] && s[23] != a[23], s[24]}));
      s = {9'h0, a[15:0]} - {9'h0, b[15:0]};
      run(OP_WORD_COMPARE, a, b, 8'h0, 2'b0);
      chk_val(32'({r.res[15:0], r.flags.z, r.flags.cy}), 32'({a[15:0], s[15:0] == 0, s[16]}));
      for (j = 0; j < 2; j++) begin
        s = j ? {9'h0, a[15:0]} - {9'h0, b[15:0]} : {9'h0, a[15:0]} + {9'h0, b[15:0]};
        run(j ? OP_WORD_SUBTRACT : OP_WORD_ADD, a, b, 8'h0, 2'b0);
        chk_val(32'({r.res[15:0], r.flags}), 32'({s[15:0], s[15], s[15:0] == 0,
                (j ? a[3:0] < b[3:0] : a[3:0] + b[3:0] > 15),
                (a[15] ^ b[15]) == 1'(j) && s[15] != a[15], s[16]}));
      end
      e = a + 1;
      run(OP_BYTE_PLUS_ONE, a, b, 8'h0, 2'b0);
      chk_val(32'({r.res[7:0], r.flags.s, r.flags.z, r.flags.ac, r.flags.pv, r.flag_we.cy}),
              32'({e[7:0], e[7], e[7:0] == 0, a[3:0] == 4'hf, a[7:0] == 8'h7f, 1'b0}));
      run(OP_BYTE_MINUS_ONE, e, b, 8'h0, 2'b0);
      chk_val(32'({r.res[7:0], r.flags.s, r.flags.z, r.flags.ac, r.flags.pv, r.flag_we.cy}),
              32'({a[7:0], a[7], a[7:0] == 0, e[3:0] == 4'h0, e[7:0] == 8'h80, 1'b0}));
      for (j = 0; j < 4; j++) begin
        run(cwad_op_t'(OP_WORD_PLUS_ONE + j), a, b, 8'h0, 2'b0);
        e = (j % 2) ? a - 1 : a + 1;
        chk_val(r.res & (j > 1 ? 32'hffffff : 32'hffff), e & (j > 1 ? 32'hffffff : 32'hffff));
        chk_flg(r.flag_we, '0);
      end
      run(OP_WORD_UNSIGNED_MULTIPLY, a, b, 8'h0, 2'b0);
      e = a[15:0] * b[15:0];
      chk_val({r.res[15:0], r.aux}, e);
      chk_flg(r.flag_we, '0);
      run(OP_WORD_SIGNED_MULTIPLY, a, b, 8'h0, 2'b0);
      p = $signed(a[15:0]) * $signed(b[15:0]);
      chk_val({r.res[15:0], r.aux}, 32'(p));
      run(OP_BYTE_UNSIGNED_MULTIPLY, a, b, 8'h0, 2'b0);
      chk_val(32'(r.res[15:0]), 32'(a[7:0]) * 32'(b[7:0]));
      chk_flg(r.flag_we, '0);
      run(OP_WORD_BY_BYTE_DIVIDE, a, {24'h0, d[7:0]}, 8'h0, 2'b0);
      e = (d[7:0] == 0) ? {8'h0, 16'hffff, a[7:0]} : {8'h0, a[15:0] / d[7:0], 8'(a[15:0] % d[7:0])};
      chk_val(32'({r.res[15:0], r.aux[7:0]}), e);
      run(OP_LONG_BY_WORD_DIVIDE, a, {16'h0, d}, 8'h0, 2'b0);
      chk_val(r.res, (d == 0) ? 32'hffffffff : a / d);
      chk_val(32'(r.aux), (d == 0) ? 32'(a[15:0]) : a % d);
      run(OP_SIGN_EXTEND_BYTE, a, b, 8'h0, 2'b0);
      chk_val(32'(r.res[15:0]), 32'({{8{a[7]}}, a[7:0]}));
      chk_flg(r.flag_we, '0);
      x = $urandom % 100;
      y = $urandom % 100;
      s = 25'(bcd(x)) + 25'(bcd(y));
      run(OP_BCD_FIX_AFTER_ADD, 32'(s[7:0]), b, 8'h0, {s[8], bcd(x) % 16 + bcd(y) % 16 > 15});
      chk_val(32'({r.res[7:0], r.flags.z, r.flags.pv, r.flags.cy}),
              32'({bcd((x + y) % 100), (x + y) % 100 == 0,
                   ~^bcd((x + y) % 100), x + y > 99}));
      s = 25'(bcd(x)) - 25'(bcd(y));
      run(OP_BCD_FIX_AFTER_SUBTRACT, 32'(s[7:0]), b, 8'h0, {s[24], bcd(x) % 16 < bcd(y) % 16});
      chk_val(32'({r.res[7:0], r.flags.z, r.flags.pv, r.flags.cy}),
              32'({bcd((x - y + 100) % 100), x == y, ~^bcd((x - y + 100) % 100), x < y}));
    end
    // loops: stalling memory, normal end after two steps, then forced overflow
    slow <= 1'b1;
    for (j = 0; j < 2; j++) begin
      run(j ? OP_SATURATING_MULTIPLY_ACCUMULATE : OP_MULTIPLY_ACCUMULATE_LOOP,
          32'h1234, b, 8'h02, 2'b0);
      chk_val(r.res, 32'h1234 + 32'(prod(0)) + 32'(prod(1)));
      chk_val(32'({r.ptr_a, r.cnt}), 32'({24'h000104, 8'h00}));
      chk_val(32'(r.ptr_b), 32'h344);
      e = (prod(0) > 0) ? 32'h7fffffff : 32'h80000000;
      run(j ? OP_SATURATING_MULTIPLY_ACCUMULATE : OP_MULTIPLY_ACCUMULATE_LOOP, e, b, 8'h04, 2'b0);
      chk_val(r.res, j ? e : e + 32'(prod(0)));
      chk_val(32'({r.cnt, r.flags.pv}), 32'({8'h03, 1'b1}));
    end
    slow <= 1'b0;
    // second start value makes the sum carry out on the first step
    for (x = 0; x < 2; x++) begin
      e = x ? 32'hff00 : 32'h0010;
      for (j = 0; j < 3 && !e[16]; j++) begin
        a = 32'(word_at(24'(24'h100 + 2 * j)));
        b = 32'(word_at(24'(24'h340 + 2 * j)));
        e = e[15:0] + ((a >= b) ? a - b : b - a);
        p = j;
      end
      run(OP_ABSOLUTE_DIFFERENCE_SUM, x ? 32'hff00 : 32'h0010, b, 8'h03, 2'b0);
      chk_val(32'({r.res[15:0], r.flags.cy, r.cnt}), 32'({e[15:0], e[16], 8'(2 - p)}));
    end
    test_done();
  end
endmodule

`default_nettype wire
